// >>> design/pwm_tb_consts.svh
// register offsets, field positions and reset values of the pwm time base and fault block
`ifndef PWM_TB_CONSTS_SVH
`define PWM_TB_CONSTS_SVH
// register byte offsets
`define OFF_CTRL        8'h00
`define OFF_PERIOD      8'h04
`define OFF_COUNT       8'h08
`define OFF_DUTY        8'h0c
`define OFF_FAULT_CFG   8'h10
`define OFF_INT_STATUS  8'h14
`define OFF_INT_MASK    8'h18
// control register fields
`define CTRL_MODE_LSB   0
`define CTRL_RUN_BIT    2
`define CTRL_PS_LSB     4
`define CTRL_EN_LSB     8
// fault configuration fields
`define FLT_A_EN_BIT    0
`define FLT_A_MOD_BIT   1
`define FLT_A_ST_BIT    2
`define FLT_B_EN_BIT    4
`define FLT_B_MOD_BIT   5
`define FLT_B_ST_BIT    6
// interrupt status bits
`define IRQ_MATCH_BIT   0
`define IRQ_ZERO_BIT    1
`define IRQ_FLT_A_BIT   2
`define IRQ_FLT_B_BIT   3
// time base modes
`define MODE_FREE       2'h0
`define MODE_SINGLE     2'h1
`define MODE_UPDOWN     2'h2
// output enable values loaded at reset
`define EN_RST_OFF      3'h0
`define EN_RST_EIGHT    3'h5
`define EN_RST_SIX      3'h4
`endif

// >>> design/pwm_tb_pkg.sv
// types shared by the pwm time base and fault block
package pwm_tb_pkg;
   typedef enum logic {DIR_UP, DIR_DOWN} dir_t;
   // one fault channel seen by software
   typedef struct packed {
      logic enable;
      logic mode;
      logic state;
   } fault_cfg_t;
   // one pwm pair as driven onto the pins
   typedef struct packed {
      logic high;
      logic low;
      logic oe;
   } pair_out_t;
endpackage

// >>> design/pwm_timebase_fault_control.sv
// pwm time base interrupts, output pin reset state and fault shutdown with an ahb-lite register slave
//
// Notes on behaviour
// - single-shot mode: period match raises interrupt event
// - after match, count clears and run clears
// - postscaler ignored in single-shot mode
// - up/down mode: interrupt when count turns upward
// - up/down mode: only every Nth zero interrupts
// - unprogrammed pin option: reset clears output enables
// - programmed pin option: reset loads 101 or 100
// - enabled outputs use configured side polarities
// - two active-low faults, second absent on small
// - enabled fault forces outputs inactive in hardware
// - each fault acts only when enabled
// - readable fault state bit per input
// - catastrophic: hold until high and software clears
// - catastrophic: resume at next period after clear
// - cycle-by-cycle: inactive while fault input low
// - cycle-by-cycle: resume next period, state self-clears
// - inactive pin level follows side polarity
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`include "pwm_tb_consts.svh"
module pwm_timebase_fault_control #(
   parameter int PER_W        = 12,
   parameter int PS_W         = 4,
   parameter bit EIGHT_OUTPUT = 1'b1
) (
   // clock and reset
   input  wire logic                        SYS_CLK,
   input  wire logic                        SRST,
   // ahb-lite slave
   input  wire logic                        HSEL,
   input  wire logic [31:0]                 HADDR,
   input  wire logic [1:0]                  HTRANS,
   input  wire logic                        HWRITE,
   input  wire logic [2:0]                  HSIZE,
   input  wire logic [31:0]                 HWDATA,
   input  wire logic                        HREADY,
   output logic      [31:0]                 HRDATA,
   output logic                             HREADYOUT,
   output logic                             HRESP,
   // configuration straps
   input  wire logic                        PIN_RESET_CONFIG_N,
   input  wire logic                        HIGH_SIDE_POLARITY,
   input  wire logic                        LOW_SIDE_POLARITY,
   // fault inputs
   input  wire logic                        FAULT_INPUT_A_N,
   input  wire logic                        FAULT_INPUT_B_N,
   // pwm pins and interrupt
   output pwm_tb_pkg::pair_out_t [3:0]      PWM_PAIR,
   output logic                             IRQ
);
   // control and data registers
   logic [1:0]        mode_sel;
   logic              time_base_run;
   logic [PS_W-1:0]   postscale;
   logic [2:0]        output_group_enable;
   logic [PER_W-1:0]  period_value;
   logic [PER_W-1:0]  duty;
   logic [3:0]        int_status;
   logic [3:0]        int_mask;
   logic [1:0]        next_mode_sel;
   logic              next_run;
   logic [PS_W-1:0]   next_postscale;
   logic [2:0]        next_enable;
   logic [PER_W-1:0]  next_period;
   logic [PER_W-1:0]  next_duty;
   logic [3:0]        next_int_status;
   logic [3:0]        next_int_mask;
   // time base
   logic [PER_W-1:0]  time_base_count;
   logic [PER_W-1:0]  next_count;
   pwm_tb_pkg::dir_t  dir;
   pwm_tb_pkg::dir_t  next_dir;
   logic [PS_W-1:0]   ps_cnt;
   logic [PS_W-1:0]   next_ps_cnt;
   logic              match_ev;
   logic              zero_ev;
   logic              zero_irq_ev;
   logic              period_start;
   // faults
   logic [1:0]        flt_meta;
   logic [1:0]        flt_sync;
   logic [1:0]        flt_raw_low;
   pwm_tb_pkg::fault_cfg_t flt_a;
   pwm_tb_pkg::fault_cfg_t flt_b;
   pwm_tb_pkg::fault_cfg_t next_flt_a;
   pwm_tb_pkg::fault_cfg_t next_flt_b;
   logic [1:0]        blk;
   logic [1:0]        next_blk;
   logic              force_off;
   // bus
   logic              dp_write;
   logic [7:0]        dp_addr;
   logic              next_dp_write;
   logic [7:0]        next_dp_addr;
   logic [31:0]       next_hrdata;
   logic              wr_ctrl;
   logic              wr_period;
   logic              wr_duty;
   logic              wr_fault;
   logic              wr_status;
   logic              wr_mask;
   pwm_tb_pkg::pair_out_t [3:0] next_pair;
   logic [2:0]        pairs_on;

   // ahb address phase captured for the data phase; zero wait states, always okay
   always_comb begin
      next_dp_write = HSEL && HREADY && HTRANS[1] && HWRITE;
      next_dp_addr  = HADDR[7:0];
      next_hrdata   = 32'h0;
      if (HADDR[7:0] == `OFF_CTRL) begin
         next_hrdata[1:0] = mode_sel;
         next_hrdata[`CTRL_RUN_BIT] = time_base_run;
         next_hrdata[`CTRL_PS_LSB +: PS_W] = postscale;
         next_hrdata[`CTRL_EN_LSB +: 3] = output_group_enable;
      end else if (HADDR[7:0] == `OFF_PERIOD) begin
         next_hrdata[PER_W-1:0] = period_value;
      end else if (HADDR[7:0] == `OFF_COUNT) begin
         next_hrdata[PER_W-1:0] = time_base_count;
      end else if (HADDR[7:0] == `OFF_DUTY) begin
         next_hrdata[PER_W-1:0] = duty;
      end else if (HADDR[7:0] == `OFF_FAULT_CFG) begin
         next_hrdata[`FLT_A_ST_BIT:`FLT_A_EN_BIT] = {flt_a.state, flt_a.mode, flt_a.enable};
         next_hrdata[`FLT_B_ST_BIT:`FLT_B_EN_BIT] = {flt_b.state, flt_b.mode, flt_b.enable};
      end else if (HADDR[7:0] == `OFF_INT_STATUS) begin
         next_hrdata[3:0] = int_status;
      end else if (HADDR[7:0] == `OFF_INT_MASK) begin
         next_hrdata[3:0] = int_mask;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         dp_write  <= 1'b0;
         dp_addr   <= 8'h00;
         HRDATA    <= 32'h0;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         dp_write  <= next_dp_write;
         dp_addr   <= next_dp_addr;
         HRDATA    <= next_hrdata;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
   end

   // write strobes during the data phase
   assign wr_ctrl   = dp_write && (dp_addr == `OFF_CTRL);
   assign wr_period = dp_write && (dp_addr == `OFF_PERIOD);
   assign wr_duty   = dp_write && (dp_addr == `OFF_DUTY);
   assign wr_fault  = dp_write && (dp_addr == `OFF_FAULT_CFG);
   assign wr_status = dp_write && (dp_addr == `OFF_INT_STATUS);
   assign wr_mask   = dp_write && (dp_addr == `OFF_INT_MASK);

   // time base counting and its events
   always_comb begin
      next_count   = time_base_count;
      next_dir     = dir;
      next_ps_cnt  = ps_cnt;
      match_ev     = 1'b0;
      zero_ev      = 1'b0;
      zero_irq_ev  = 1'b0;
      period_start = 1'b0;
      if (time_base_run) begin
         case (mode_sel)
            `MODE_SINGLE: begin
               if (time_base_count == period_value) begin
                  match_ev   = 1'b1;
                  next_count = '0;
               end else begin
                  next_count = time_base_count + 1'b1;
               end
               period_start = (time_base_count == '0);
            end
            `MODE_FREE: begin
               if (time_base_count >= period_value) begin
                  next_count   = '0;
                  period_start = 1'b1;
               end else begin
                  next_count = time_base_count + 1'b1;
               end
            end
            default: begin
               if (dir == pwm_tb_pkg::DIR_UP) begin
                  if (time_base_count >= period_value) begin
                     next_dir   = pwm_tb_pkg::DIR_DOWN;
                     next_count = time_base_count - 1'b1;
                  end else begin
                     next_count = time_base_count + 1'b1;
                  end
               end else if (time_base_count == '0) begin
                  next_dir     = pwm_tb_pkg::DIR_UP;
                  next_count   = {{(PER_W-1){1'b0}}, 1'b1};
                  zero_ev      = 1'b1;
                  period_start = 1'b1;
               end else begin
                  next_count = time_base_count - 1'b1;
               end
               if (zero_ev) begin
                  if (ps_cnt >= postscale) begin
                     next_ps_cnt = '0;
                     zero_irq_ev = 1'b1;
                  end else begin
                     next_ps_cnt = ps_cnt + 1'b1;
                  end
               end
            end
         endcase
      end
      if (wr_ctrl) begin
         next_ps_cnt = '0;
         next_dir    = pwm_tb_pkg::DIR_UP;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         time_base_count <= '0;
         dir             <= pwm_tb_pkg::DIR_UP;
         ps_cnt          <= '0;
      end else begin
         time_base_count <= next_count;
         dir             <= next_dir;
         ps_cnt          <= next_ps_cnt;
      end
   end

   // software registers and sticky interrupt status, set winning over clear
   always_comb begin
      next_mode_sel   = mode_sel;
      next_run        = time_base_run;
      next_postscale  = postscale;
      next_enable     = output_group_enable;
      next_period     = period_value;
      next_duty       = duty;
      next_int_mask   = int_mask;
      next_int_status = int_status;
      if (wr_ctrl) begin
         next_mode_sel  = HWDATA[`CTRL_MODE_LSB +: 2];
         next_run       = HWDATA[`CTRL_RUN_BIT];
         next_postscale = HWDATA[`CTRL_PS_LSB +: PS_W];
         next_enable    = HWDATA[`CTRL_EN_LSB +: 3];
      end
      if (match_ev) begin
         next_run = 1'b0;
      end
      if (wr_period) begin
         next_period = HWDATA[PER_W-1:0];
      end
      if (wr_duty) begin
         next_duty = HWDATA[PER_W-1:0];
      end
      if (wr_mask) begin
         next_int_mask = HWDATA[3:0];
      end
      if (wr_status) begin
         next_int_status = int_status & ~HWDATA[3:0];
      end
      next_int_status[`IRQ_MATCH_BIT] = next_int_status[`IRQ_MATCH_BIT] | match_ev;
      next_int_status[`IRQ_ZERO_BIT]  = next_int_status[`IRQ_ZERO_BIT] | zero_irq_ev;
      next_int_status[`IRQ_FLT_A_BIT] = next_int_status[`IRQ_FLT_A_BIT] | (next_flt_a.state & ~flt_a.state);
      next_int_status[`IRQ_FLT_B_BIT] = next_int_status[`IRQ_FLT_B_BIT] | (next_flt_b.state & ~flt_b.state);
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         mode_sel            <= `MODE_FREE;
         time_base_run       <= 1'b0;
         postscale           <= '0;
         // pin option strap decides the enables that reset leaves
         if (PIN_RESET_CONFIG_N) begin
            output_group_enable <= `EN_RST_OFF;
         end else begin
            output_group_enable <= EIGHT_OUTPUT ? `EN_RST_EIGHT : `EN_RST_SIX;
         end
         period_value        <= '0;
         duty                <= '0;
         int_status          <= 4'h0;
         int_mask            <= 4'h0;
         IRQ                 <= 1'b0;
      end else begin
         mode_sel            <= next_mode_sel;
         time_base_run       <= next_run;
         postscale           <= next_postscale;
         output_group_enable <= next_enable;
         period_value        <= next_period;
         duty                <= next_duty;
         int_status          <= next_int_status;
         int_mask            <= next_int_mask;
         IRQ                 <= |(next_int_status & next_int_mask);
      end
   end

   // fault status and blocking, judged on synchronised inputs
   assign flt_raw_low = {~FAULT_INPUT_B_N & EIGHT_OUTPUT, ~FAULT_INPUT_A_N};
   always_comb begin
      next_flt_a = flt_a;
      next_flt_b = flt_b;
      if (wr_fault) begin
         next_flt_a.enable = HWDATA[`FLT_A_EN_BIT];
         next_flt_a.mode   = HWDATA[`FLT_A_MOD_BIT];
         next_flt_b.enable = HWDATA[`FLT_B_EN_BIT] & EIGHT_OUTPUT;
         next_flt_b.mode   = HWDATA[`FLT_B_MOD_BIT] & EIGHT_OUTPUT;
         // software clears a catastrophic state only once the input is back high
         if (HWDATA[`FLT_A_ST_BIT] && flt_sync[0]) begin
            next_flt_a.state = 1'b0;
         end
         if (HWDATA[`FLT_B_ST_BIT] && flt_sync[1]) begin
            next_flt_b.state = 1'b0;
         end
      end
      // cycle-by-cycle states clear themselves at a period start
      if (period_start && flt_a.mode && flt_sync[0]) begin
         next_flt_a.state = 1'b0;
      end
      if (period_start && flt_b.mode && flt_sync[1]) begin
         next_flt_b.state = 1'b0;
      end
      if (flt_a.enable && !flt_sync[0]) begin
         next_flt_a.state = 1'b1;
      end
      if (flt_b.enable && !flt_sync[1]) begin
         next_flt_b.state = 1'b1;
      end
      // outputs come back only at a period start once the state is gone
      next_blk = blk;
      if (next_flt_a.state) begin
         next_blk[0] = 1'b1;
      end else if (period_start && flt_sync[0]) begin
         next_blk[0] = 1'b0;
      end
      if (next_flt_b.state) begin
         next_blk[1] = 1'b1;
      end else if (period_start && flt_sync[1]) begin
         next_blk[1] = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         flt_meta <= 2'h3;
         flt_sync <= 2'h3;
         flt_a    <= '0;
         flt_b    <= '0;
         blk      <= 2'h0;
      end else begin
         flt_meta <= {FAULT_INPUT_B_N | ~EIGHT_OUTPUT, FAULT_INPUT_A_N};
         flt_sync <= flt_meta;
         flt_a    <= next_flt_a;
         flt_b    <= next_flt_b;
         blk      <= next_blk;
      end
   end

   // raw inputs force the pins straight away, blocks hold them until release
   assign force_off = (flt_a.enable && (flt_raw_low[0] || blk[0]))
                   || (flt_b.enable && (flt_raw_low[1] || blk[1]));

   // number of pairs handed to the pwm from the output enable field
   assign pairs_on = output_group_enable[2] ? (output_group_enable[0] ? 3'h4 : 3'h3)
                   : output_group_enable[1] ? 3'h2 : {2'h0, output_group_enable[0]};

   // pin levels: active level xor polarity, inactive level is the polarity itself
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         next_pair[i].oe   = (3'(i) < pairs_on) && (EIGHT_OUTPUT || i < 3);
         next_pair[i].high = HIGH_SIDE_POLARITY;
         next_pair[i].low  = LOW_SIDE_POLARITY;
         if (!force_off && time_base_run) begin
            next_pair[i].high = (time_base_count < duty) ^ HIGH_SIDE_POLARITY;
            next_pair[i].low  = !(time_base_count < duty) ^ LOW_SIDE_POLARITY;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         for (int i = 0; i < 4; i++) begin
            PWM_PAIR[i].high <= 1'b0;
            PWM_PAIR[i].low  <= 1'b0;
            PWM_PAIR[i].oe   <= 1'b0;
         end
      end else begin
         PWM_PAIR <= next_pair;
      end
   end

   // checks on the time base and fault behaviour
   sequence ss_match_s;
      time_base_run && mode_sel == `MODE_SINGLE && time_base_count == period_value;
   endsequence
   sequence ss_stopped_s;
      time_base_count == '0 && !time_base_run;
   endsequence

   ss_stop_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      ss_match_s and !wr_ctrl |=> ss_stopped_s ##1 (time_base_count == '0))
      else $error("single-shot did not stop at zero");

   ss_irq_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      ss_match_s |=> int_status[`IRQ_MATCH_BIT])
      else $error("single-shot match gave no interrupt");

   ud_turn_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      zero_ev && !wr_ctrl |=> dir == pwm_tb_pkg::DIR_UP && time_base_count == 1)
      else $error("up/down time base did not turn upward at zero");

   ud_skip_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      zero_ev && ps_cnt < postscale && !int_status[`IRQ_ZERO_BIT] && !wr_ctrl
      |=> !int_status[`IRQ_ZERO_BIT] && ps_cnt == $past(ps_cnt) + 1'b1)
      else $error("postscaler let a zero crossing through");

   flt_force_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      flt_a.enable && !FAULT_INPUT_A_N |=> PWM_PAIR[0].high == HIGH_SIDE_POLARITY
      && PWM_PAIR[0].low == LOW_SIDE_POLARITY)
      else $error("fault did not force outputs inactive");

   flt_off_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      !flt_a.enable && !flt_a.state && !wr_fault |=> !flt_a.state)
      else $error("disabled fault changed state");

   cbc_hold_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      flt_a.enable && flt_a.mode && !flt_sync[0] && !flt_meta[0] |=> flt_a.state [*2])
      else $error("cycle-by-cycle fault released while input low");

   cbc_clear_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      flt_a.mode && flt_a.state && period_start && flt_sync[0] && !(flt_a.enable && !flt_sync[0])
      |=> !flt_a.state && !blk[0])
      else $error("cycle-by-cycle fault did not self-clear");

   cat_hold_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      !flt_a.mode && flt_a.state && !wr_fault |=> flt_a.state && blk[0])
      else $error("catastrophic fault released without software");

endmodule // pwm_timebase_fault_control

// >>> tb/pwm_partner.sv
// power stage and open fault sources facing the pwm block
`timescale 1ns/10ps
module pwm_partner (
   // clock
   input  wire logic                   clk,
   // fault sources commanded by the bench
   input  wire logic                   pull_a,
   input  wire logic                   pull_b,
   // pins and polarity straps
   input  wire pwm_tb_pkg::pair_out_t [3:0] pins,
   input  wire logic                   hp,
   input  wire logic                   lp,
   // pulled-up fault lines and stage status
   output logic                        fa_n,
   output logic                        fb_n,
   output logic                        overlap
);
   // open sources on pulled-up lines, released reads high
   assign fa_n = pull_a ? 1'b0 : 1'b1;
   assign fb_n = pull_b ? 1'b0 : 1'b1;
   // stage latches a shoot-through of any driven pair
   initial overlap = 1'b0;
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         if (pins[i].oe && (pins[i].high ^ hp) && (pins[i].low ^ lp)) begin
            overlap <= 1'b1;
         end
      end
   end
endmodule // pwm_partner

// >>> tb/tb.sv
// self-checking bench for the pwm time base and fault block
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module tb;
   logic                      clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, cfg_n = 1'b1;
   logic                      hp = 1'b0, lp = 1'b0, pull_a = 1'b0, pull_b = 1'b0;
   logic [31:0]               haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0]                htrans = 2'h0;
   logic                      hready, hresp, irq, fa_n, fb_n, overlap;
   pwm_tb_pkg::pair_out_t [3:0] pins;
   logic [11:0]               idle_v;
   int                        failures = 0, n_checks = 0, seed = 55673, cyc = 0, p, ps, t0, n;

   pwm_timebase_fault_control #(.PER_W(12), .PS_W(4), .EIGHT_OUTPUT(1'b1)) pwm_timebase_fault_control_i (
      .SYS_CLK(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
      .PIN_RESET_CONFIG_N(cfg_n), .HIGH_SIDE_POLARITY(hp), .LOW_SIDE_POLARITY(lp),
      .FAULT_INPUT_A_N(fa_n), .FAULT_INPUT_B_N(fb_n), .PWM_PAIR(pins), .IRQ(irq));
   pwm_partner pwm_partner_i (.clk(clk), .pull_a(pull_a), .pull_b(pull_b), .pins(pins), .hp(hp), .lp(lp),
      .fa_n(fa_n), .fb_n(fb_n), .overlap(overlap));

   // clock and hang limit
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         failures++;
         test_done();
      end
   end

   // one single ahb-lite transfer, read data left in rd
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   // reset with random polarity straps
   task automatic do_rst(input logic c);
      int r;
      r = $random(seed);
      srst <= 1'b1;
      cfg_n <= c;
      hp <= r[0];
      lp <= r[1];
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask

   // count cycles whose pins differ from the idle pattern
   task automatic watch(input int k, output int m);
      m = 0;
      repeat (k) begin
         @(posedge clk);
         #1;
         if (pins !== idle_v) m++;
      end
   endtask

   // wait for a rising interrupt, bounded
   task automatic wait_irq(output int t);
      int k;
      k = 0;
      while (irq === 1'b1 && k < 3000) begin
         @(posedge clk);
         k++;
      end
      while (irq !== 1'b1 && k < 3000) begin
         @(posedge clk);
         k++;
      end
      // a wait that runs out is a mismatch
      if (k >= 3000) failures++;
      t = cyc;
   endtask

   // verdict
   task automatic test_done();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      do_rst(1'b1);
      idle_v = {4{hp, lp, 1'b0}};
      `CHK(pins, idle_v)
      bus(1'b0, 8'h00, 32'h0);
      `CHK(rd[10:8], 3'h0)
      bus(1'b1, 8'h40, 32'hffff_ffff);
      bus(1'b0, 8'h40, 32'h0);
      `CHK(rd, 32'h0)
      $display("test reset_unprogrammed done");
      do_rst(1'b0);
      idle_v = {4{hp, lp, 1'b1}};
      `CHK(pins, idle_v)
      bus(1'b0, 8'h00, 32'h0);
      `CHK(rd[10:8], 3'h5)
      $display("test reset_programmed done");
      p = 8 + ($random(seed) & 7);
      ps = $random(seed) & 15;
      bus(1'b1, 8'h04, p);
      bus(1'b1, 8'h0c, p / 2);
      bus(1'b1, 8'h18, 32'hf);
      bus(1'b1, 8'h00, 32'h505 | (ps << 4));
      wait_irq(t0);
      bus(1'b0, 8'h08, 32'h0);
      `CHK(rd, 32'h0)
      bus(1'b0, 8'h00, 32'h0);
      `CHK(rd, 32'h501 | (ps << 4))
      bus(1'b0, 8'h14, 32'h0);
      `CHK(rd, 32'h1)
      bus(1'b1, 8'h14, 32'h1);
      repeat (3 * p) @(posedge clk);
      `CHK(irq, 1'b0)
      $display("test single_shot done");
      ps = 1 + ($random(seed) & 3);
      bus(1'b1, 8'h00, 32'h506 | (ps << 4) | ($random(seed) & 1));
      wait_irq(t0);
      bus(1'b1, 8'h14, 32'h2);
      wait_irq(n);
      `CHK(n - t0, (ps + 1) * 2 * p)
      $display("test up_down done");
      bus(1'b1, 8'h00, 32'h504);
      bus(1'b1, 8'h14, 32'hf);
      bus(1'b1, 8'h10, 32'h3);
      pull_a <= 1'b1;
      watch(2 * p, n);
      `CHK(n, 0)
      bus(1'b0, 8'h10, 32'h0);
      `CHK(rd, 32'h7)
      `CHK(hresp, 1'b0)
      `CHK(irq, 1'b1)
      pull_a <= 1'b0;
      repeat (p + 6) @(posedge clk);
      bus(1'b0, 8'h10, 32'h0);
      `CHK(rd, 32'h3)
      watch(2 * p, n);
      `CHK(n > 0, 1'b1)
      $display("test fault_cycle done");
      bus(1'b1, 8'h10, 32'h10);
      pull_b <= 1'b1;
      repeat (8) @(posedge clk);
      pull_b <= 1'b0;
      watch(3 * p, n);
      `CHK(n, 0)
      bus(1'b0, 8'h10, 32'h0);
      `CHK(rd, 32'h50)
      bus(1'b1, 8'h10, 32'h50);
      watch(3 * p, n);
      `CHK(n > 0, 1'b1)
      bus(1'b0, 8'h10, 32'h0);
      `CHK(rd, 32'h10)
      $display("test fault_catastrophic done");
      bus(1'b1, 8'h10, 32'h0);
      pull_a <= 1'b1;
      pull_b <= 1'b1;
      watch(2 * p, n);
      `CHK(n > 0, 1'b1)
      @(posedge clk);
      pull_a <= 1'b0;
      pull_b <= 1'b0;
      `CHK(overlap, 1'b0)
      $display("test fault_disabled done");
      test_done();
   end
endmodule // tb
